// >>> src/ubrg_consts.svh
// Behaviour
// - Async: source over divisor is the sampling clock, then over 16 or 8.
// - Oversample select one samples at eight times bit rate, zero at sixteen.
// - Async bit rate is source over 8 x (2 - oversample) x divisor.
// - Nonzero fractional part adds eighths of a source period to the divisor.
// - Fractional bit rate uses divisor plus fractional part over eight.
// - Fractional division applies only in normal asynchronous port mode.
// - Sync and SPI bit clock is source over divisor, no oversampling.
// - Sync with external source uses the pin undivided; divisor ignored.
// - Undivided peripheral source gives 50:50 pin even for odd divisor above one.
// - Rate adjust code maps to factors 1,2,4,8,16,32,12,20.
// - Clock division code maps to 372..1860 and 512..2048 as tabulated.
// - Card mode divides by divisor and may drive that clock on the pin.
// - Card mode bit clock is card clock divided by ratio up to 2047.
// - Elementary time unit ratio resets to 0x174.
// - Divisor is 16 bits; zero stops generation, one bypasses the divider.
// - Source select picks peripheral clock, that clock over 8, or the pin.
`ifndef UBRG_CONSTS_SVH
`define UBRG_CONSTS_SVH

// ----------------------------------------------------------------------
// Source selection and fixed dividers
// ----------------------------------------------------------------------
`define UBRG_SRC_PCLK 2'h0
`define UBRG_SRC_PDIV 2'h1
`define UBRG_SRC_EXT 2'h3
`define UBRG_PRESC_DIV 4'h8
`define UBRG_OVER_8 5'h08
`define UBRG_OVER_16 5'h10
`define UBRG_FRAC_W 3
`define UBRG_ETU_RESET 11'h174

// ----------------------------------------------------------------------
// Clock division factors
// ----------------------------------------------------------------------
`define UBRG_FI_372 12'h174
`define UBRG_FI_558 12'h22E
`define UBRG_FI_744 12'h2E8
`define UBRG_FI_1116 12'h45C
`define UBRG_FI_1488 12'h5D0
`define UBRG_FI_1860 12'h744
`define UBRG_FI_512 12'h200
`define UBRG_FI_768 12'h300
`define UBRG_FI_1024 12'h400
`define UBRG_FI_1536 12'h600
`define UBRG_FI_2048 12'h800

// ----------------------------------------------------------------------
// Rate adjustment factors
// ----------------------------------------------------------------------
`define UBRG_DI_1 6'h01
`define UBRG_DI_2 6'h02
`define UBRG_DI_4 6'h04
`define UBRG_DI_8 6'h08
`define UBRG_DI_16 6'h10
`define UBRG_DI_32 6'h20
`define UBRG_DI_12 6'h0C
`define UBRG_DI_20 6'h14

`endif

// >>> src/ubrg_pkg.sv
package ubrg_pkg;

    typedef enum logic [1:0] {
        UBRG_ASYNC,
        UBRG_SYNC,
        UBRG_SPI,
        UBRG_ISO
    } ubrg_mode_t;

endpackage

// >>> src/ubrg_tick_div.sv
`timescale 1ns/1ns
module ubrg_tick_div #(
    parameter int W = 4
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic clear,
    input wire logic tick,
    input wire logic [W-1:0] limit,
    output logic strobe_r
);

    logic [W-1:0] cnt_r;
    logic last;

    if (W < 2) begin : g_chk
        $error("ubrg_tick_div: width too small");
    end

    // A lowered limit would otherwise strand the counter above it.
    assign last = ({1'b0, cnt_r} + {{W{1'b0}}, 1'b1}) >= {1'b0, limit};

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= '0;
            strobe_r <= 1'b0;
        end else if (clear || limit == '0) begin
            cnt_r <= '0;
            strobe_r <= 1'b0;
        end else if (tick) begin
            strobe_r <= last;
            cnt_r <= last ? '0 : cnt_r + {{(W-1){1'b0}}, 1'b1};
        end else begin
            strobe_r <= 1'b0;
        end
    end

    a_div_strobe: assert property (
        @(posedge clock) disable iff (!arst_n)
        (tick && !clear && limit != '0 && last) |=> strobe_r)
        else $error("divider missed its terminal strobe");

endmodule

// >>> src/ubrg_core.sv
`timescale 1ns/1ns
`include "ubrg_consts.svh"
module ubrg_core #(
    parameter int CD_W = 16,
    parameter int ETU_W = 11
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic enable,
    input wire ubrg_pkg::ubrg_mode_t mode,
    input wire logic normal_mode,
    input wire logic oversample8,
    input wire logic [1:0] clock_source_select,
    input wire logic clock_output_enable,
    input wire logic [CD_W-1:0] clock_divisor,
    input wire logic [`UBRG_FRAC_W-1:0] fractional_part,
    input wire logic etu_ratio_wr,
    input wire logic [ETU_W-1:0] etu_ratio_wdata,
    input wire logic [3:0] rate_adjust_code,
    input wire logic [3:0] clock_division_code,
    input wire logic sck_in,
    output logic sample_stb_r,
    output logic bit_stb_r,
    output logic sck_out,
    output logic sck_oe_r,
    output logic [ETU_W-1:0] etu_divide_ratio_r,
    output logic [11:0] fi_factor_r,
    output logic [5:0] di_factor_r
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (CD_W < 2 || ETU_W < 11) begin : g_chk
        $error("ubrg_core: divisor or ratio width unsupported");
    end

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic sck_prev_r;
    logic ext_edge;
    logic presc_stb;
    logic over_stb;
    logic etu_stb;
    logic src_tick;
    logic ext_sync;
    logic frac_on;
    logic carry;
    logic div_last;
    logic div_run;
    logic gen_on;
    logic odd_fast;
    logic [`UBRG_FRAC_W:0] acc_sum;
    logic [`UBRG_FRAC_W-1:0] acc_r;
    logic [CD_W:0] period;
    logic [CD_W-1:0] cnt_r;
    logic [CD_W-1:0] cnt_nxt;
    logic [CD_W-1:0] half;
    logic div_tick_r;
    logic sck_lvl_r;
    logic sck_ext_r;
    logic [4:0] over_limit;

    // ------------------------------------------------------------------
    // Source clock selection
    // ------------------------------------------------------------------
    // The pin is taken as synchronous, so one stage suffices for edges.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sck_prev_r <= 1'b0;
        end else begin
            sck_prev_r <= sck_in;
        end
    end

    assign ext_edge = sck_in & ~sck_prev_r;

    ubrg_tick_div #(
        .W(4)
    ) u_presc (
        .clock(clock),
        .arst_n(arst_n),
        .clear(!enable),
        .tick(1'b1),
        .limit(`UBRG_PRESC_DIV),
        .strobe_r(presc_stb)
    );

    always_comb begin
        case (clock_source_select)
            `UBRG_SRC_PCLK: src_tick = 1'b1;
            `UBRG_SRC_PDIV: src_tick = presc_stb;
            `UBRG_SRC_EXT: src_tick = ext_edge;
            default: src_tick = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Divisor counter with fractional stretch
    // ------------------------------------------------------------------
    assign ext_sync = (mode == ubrg_pkg::UBRG_SYNC) &&
                      (clock_source_select == `UBRG_SRC_EXT);
    assign frac_on = (mode == ubrg_pkg::UBRG_ASYNC) && normal_mode &&
                     (fractional_part != '0);
    // Over eight periods, as many as the fraction are one tick longer.
    assign acc_sum = {1'b0, acc_r} + {1'b0, fractional_part};
    assign carry = frac_on && acc_sum[`UBRG_FRAC_W];
    assign period = {1'b0, clock_divisor} + {{CD_W{1'b0}}, carry};
    assign div_last = ({1'b0, cnt_r} + {{CD_W{1'b0}}, 1'b1}) >= period;
    assign div_run = enable && (clock_divisor != '0) && !ext_sync;

    always_comb begin
        cnt_nxt = cnt_r;
        if (!div_run) begin
            cnt_nxt = '0;
        end else if (src_tick) begin
            cnt_nxt = div_last ? '0 : cnt_r + {{(CD_W-1){1'b0}}, 1'b1};
        end
    end

    // Without a fraction, a divisor of one makes every source tick a divided tick.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= '0;
            div_tick_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            div_tick_r <= div_run && src_tick && div_last;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            acc_r <= '0;
        end else if (!frac_on || !div_run) begin
            acc_r <= '0;
        end else if (src_tick && div_last) begin
            acc_r <= acc_sum[`UBRG_FRAC_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Oversampling and elementary time unit dividers
    // ------------------------------------------------------------------
    assign over_limit = oversample8 ? `UBRG_OVER_8 : `UBRG_OVER_16;

    ubrg_tick_div #(
        .W(5)
    ) u_over (
        .clock(clock),
        .arst_n(arst_n),
        .clear(!enable || mode != ubrg_pkg::UBRG_ASYNC),
        .tick(div_tick_r),
        .limit(over_limit),
        .strobe_r(over_stb)
    );

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            etu_divide_ratio_r <= `UBRG_ETU_RESET;
        end else if (etu_ratio_wr) begin
            etu_divide_ratio_r <= etu_ratio_wdata;
        end
    end

    ubrg_tick_div #(
        .W(ETU_W)
    ) u_etu (
        .clock(clock),
        .arst_n(arst_n),
        .clear(!enable || mode != ubrg_pkg::UBRG_ISO),
        .tick(div_tick_r),
        .limit(etu_divide_ratio_r),
        .strobe_r(etu_stb)
    );

    // ------------------------------------------------------------------
    // Strobes to receiver and transmitter
    // ------------------------------------------------------------------
    // Strobes keep everything on one clock; no derived clocks leave here.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sample_stb_r <= 1'b0;
            bit_stb_r <= 1'b0;
        end else if (!enable) begin
            sample_stb_r <= 1'b0;
            bit_stb_r <= 1'b0;
        end else begin
            case (mode)
                ubrg_pkg::UBRG_ASYNC: begin
                    sample_stb_r <= div_tick_r;
                    bit_stb_r <= over_stb;
                end
                ubrg_pkg::UBRG_SYNC, ubrg_pkg::UBRG_SPI: begin
                    sample_stb_r <= ext_sync ? ext_edge : div_tick_r;
                    bit_stb_r <= ext_sync ? ext_edge : div_tick_r;
                end
                ubrg_pkg::UBRG_ISO: begin
                    sample_stb_r <= div_tick_r;
                    bit_stb_r <= etu_stb;
                end
                default: begin
                    sample_stb_r <= 1'b0;
                    bit_stb_r <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Serial clock pin
    // ------------------------------------------------------------------
    assign half = clock_divisor >> 1;
    assign gen_on = div_run && clock_output_enable &&
                    (mode != ubrg_pkg::UBRG_ASYNC);
    // Only an odd divisor on the raw clock needs the half-cycle stretch.
    assign odd_fast = clock_divisor[0] &&
                      (clock_source_select == `UBRG_SRC_PCLK);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sck_lvl_r <= 1'b0;
            sck_oe_r <= 1'b0;
        end else begin
            sck_lvl_r <= gen_on && (cnt_nxt < half);
            sck_oe_r <= enable && clock_output_enable &&
                        (mode != ubrg_pkg::UBRG_ASYNC) &&
                        (clock_source_select != `UBRG_SRC_EXT);
        end
    end

    // Falling-edge copy extends the high phase by half a cycle, so an
    // odd divisor still yields equal halves. A divisor of one cannot be
    // shown on the pin and leaves it low.
    always_ff @(negedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sck_ext_r <= 1'b0;
        end else begin
            sck_ext_r <= odd_fast && sck_lvl_r;
        end
    end

    assign sck_out = sck_lvl_r | sck_ext_r;

    // ------------------------------------------------------------------
    // Card factor decode
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            fi_factor_r <= '0;
        end else begin
            case (clock_division_code)
                4'h0, 4'h1: fi_factor_r <= `UBRG_FI_372;
                4'h2: fi_factor_r <= `UBRG_FI_558;
                4'h3: fi_factor_r <= `UBRG_FI_744;
                4'h4: fi_factor_r <= `UBRG_FI_1116;
                4'h5: fi_factor_r <= `UBRG_FI_1488;
                4'h6: fi_factor_r <= `UBRG_FI_1860;
                4'h9: fi_factor_r <= `UBRG_FI_512;
                4'hA: fi_factor_r <= `UBRG_FI_768;
                4'hB: fi_factor_r <= `UBRG_FI_1024;
                4'hC: fi_factor_r <= `UBRG_FI_1536;
                4'hD: fi_factor_r <= `UBRG_FI_2048;
                default: fi_factor_r <= '0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            di_factor_r <= '0;
        end else begin
            case (rate_adjust_code)
                4'h1: di_factor_r <= `UBRG_DI_1;
                4'h2: di_factor_r <= `UBRG_DI_2;
                4'h3: di_factor_r <= `UBRG_DI_4;
                4'h4: di_factor_r <= `UBRG_DI_8;
                4'h5: di_factor_r <= `UBRG_DI_16;
                4'h6: di_factor_r <= `UBRG_DI_32;
                4'h8: di_factor_r <= `UBRG_DI_12;
                4'h9: di_factor_r <= `UBRG_DI_20;
                default: di_factor_r <= '0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_cd_zero_idle: assert property (
        @(posedge clock) disable iff (!arst_n)
        (clock_divisor == '0) |=> !div_tick_r)
        else $error("divided tick with zero divisor");

    a_bypass_rate: assert property (
        @(posedge clock) disable iff (!arst_n)
        (enable && clock_divisor == {{(CD_W-1){1'b0}}, 1'b1} && !frac_on &&
         clock_source_select == `UBRG_SRC_PCLK) |=> div_tick_r)
        else $error("bypassed divider did not tick every cycle");

    a_ext_direct: assert property (
        @(posedge clock) disable iff (!arst_n)
        (enable && ext_sync && ext_edge) |=> (bit_stb_r && !div_tick_r))
        else $error("external clock edge not passed straight through");

    a_sync_no_over: assert property (
        @(posedge clock) disable iff (!arst_n)
        (enable && !ext_sync && div_tick_r &&
         (mode == ubrg_pkg::UBRG_SYNC || mode == ubrg_pkg::UBRG_SPI))
        |=> bit_stb_r)
        else $error("synchronous bit strobe not equal to divided tick");

    a_frac_normal: assert property (
        @(posedge clock) disable iff (!arst_n)
        (div_run && src_tick && (mode != ubrg_pkg::UBRG_ASYNC ||
         !normal_mode) && ({1'b0, cnt_r} + {{CD_W{1'b0}}, 1'b1} ==
         {1'b0, clock_divisor})) |=> div_tick_r)
        else $error("fraction applied outside normal mode");

    a_fi_decode: assert property (
        @(posedge clock) disable iff (!arst_n)
        (clock_division_code == 4'h2) |=> (fi_factor_r == `UBRG_FI_558))
        else $error("clock division code 2 decoded wrongly");

    a_di_decode: assert property (
        @(posedge clock) disable iff (!arst_n)
        (rate_adjust_code == 4'h8) |=> (di_factor_r == `UBRG_DI_12))
        else $error("rate adjust code 8 decoded wrongly");

    a_card_clk_oe: assert property (
        @(posedge clock) disable iff (!arst_n)
        (enable && clock_output_enable && mode == ubrg_pkg::UBRG_ISO &&
         clock_source_select != `UBRG_SRC_EXT) |=> sck_oe_r)
        else $error("card clock output not enabled");

endmodule

// >>> bench/ubrg_serial_peer.sv
`timescale 1ns/1ns
module ubrg_serial_peer (
    input wire logic clock,
    input wire logic ext_run,
    input wire logic [7:0] ext_half,
    input wire logic meas_on,
    input wire logic sck_out,
    input wire logic sck_oe_r,
    output logic sck_in,
    output int hi_cnt,
    output int tot_cnt
);
    int ph = 0;

    initial begin
        sck_in = 1'b0;
        hi_cnt = 0;
        tot_cnt = 0;
    end

    // ------------------------------------------------------------------
    // External serial clock
    // ------------------------------------------------------------------
    // The clock stands low outside a run, and a half period of at least
    // two system cycles keeps it four or more times slower.
    always @(negedge clock) begin
        if (!ext_run) begin
            sck_in <= 1'b0;
            ph <= 0;
        end else if (ph + 1 >= int'(ext_half)) begin
            sck_in <= ~sck_in;
            ph <= 0;
        end else begin
            ph <= ph + 1;
        end
    end

    // ------------------------------------------------------------------
    // Card clock duty measurement
    // ------------------------------------------------------------------
    // Sampling mid-phase keeps the count clear of both clock edges, since
    // the pin may change on either of them.
    always @(posedge clock) begin
        if (meas_on) begin
            #10;
            tot_cnt = tot_cnt + 2;
            hi_cnt = hi_cnt + int'(sck_out === 1'b1 && sck_oe_r === 1'b1);
            #20;
            hi_cnt = hi_cnt + int'(sck_out === 1'b1 && sck_oe_r === 1'b1);
        end
    end
endmodule

// >>> bench/usart_baud_rate_generator_tb_top.sv
`timescale 1ns/1ns
module usart_baud_rate_generator_tb_top;
    localparam int EXT_HALF = 2;
    localparam int LIMIT = 40000;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic enable = 1'b0;
    ubrg_pkg::ubrg_mode_t mode = ubrg_pkg::UBRG_ASYNC;
    logic normal_mode = 1'b1;
    logic oversample8 = 1'b0;
    logic [1:0] clock_source_select = 2'h0;
    logic clock_output_enable = 1'b0;
    logic [15:0] clock_divisor = 16'h0000;
    logic [2:0] fractional_part = 3'h0;
    logic etu_ratio_wr = 1'b0;
    logic [10:0] etu_ratio_wdata = 11'h000;
    logic [3:0] rate_adjust_code = 4'h0;
    logic [3:0] clock_division_code = 4'h0;
    logic sck_in, sample_stb_r, bit_stb_r, sck_out, sck_oe_r;
    logic [10:0] etu_divide_ratio_r;
    logic [11:0] fi_factor_r;
    logic [5:0] di_factor_r;
    logic ext_run = 1'b0;
    logic meas_on = 1'b0;
    int hi_cnt, tot_cnt;
    int ns = 0;
    int nb = 0;
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [31:0] seed = 32'hC21B259E;

    always #20 clock = ~clock;

    ubrg_core u_ubrg_core (.clock(clock), .arst_n(arst_n), .enable(enable),
        .mode(mode), .normal_mode(normal_mode), .oversample8(oversample8),
        .clock_source_select(clock_source_select),
        .clock_output_enable(clock_output_enable),
        .clock_divisor(clock_divisor), .fractional_part(fractional_part),
        .etu_ratio_wr(etu_ratio_wr), .etu_ratio_wdata(etu_ratio_wdata),
        .rate_adjust_code(rate_adjust_code),
        .clock_division_code(clock_division_code), .sck_in(sck_in),
        .sample_stb_r(sample_stb_r), .bit_stb_r(bit_stb_r),
        .sck_out(sck_out), .sck_oe_r(sck_oe_r),
        .etu_divide_ratio_r(etu_divide_ratio_r),
        .fi_factor_r(fi_factor_r), .di_factor_r(di_factor_r));

    ubrg_serial_peer u_ubrg_serial_peer (.clock(clock), .ext_run(ext_run),
        .ext_half(8'(EXT_HALF)), .meas_on(meas_on), .sck_out(sck_out),
        .sck_oe_r(sck_oe_r), .sck_in(sck_in), .hi_cnt(hi_cnt),
        .tot_cnt(tot_cnt));

    // ------------------------------------------------------------------
    // Reference model and helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic int fi_exp(input int c);
        case (c)
            0, 1: return 372;
            2: return 558;
            3: return 744;
            4: return 1116;
            5: return 1488;
            6: return 1860;
            9: return 512;
            10: return 768;
            11: return 1024;
            12: return 1536;
            13: return 2048;
            default: return 0;
        endcase
    endfunction

    function automatic int di_exp(input int c);
        case (c)
            1: return 1;
            2: return 2;
            3: return 4;
            4: return 8;
            5: return 16;
            6: return 32;
            8: return 12;
            9: return 20;
            default: return 0;
        endcase
    endfunction

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        if (meas_on && sample_stb_r === 1'b1) ns <= ns + 1;
        if (meas_on && bit_stb_r === 1'b1) nb <= nb + 1;
    end

    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            err_count++;
            summarize();
        end
    end

    // The window spans whole repeats of the strobe pattern, so the pulse
    // count inside it is exact whatever the starting phase.
    task automatic run_case(input string nm, input ubrg_pkg::ubrg_mode_t md,
        input logic nrm, input logic o8, input logic [1:0] sel, input int n,
        input int f, input int ratio, input logic duty);
        int t, fe, len, k, es, eb, h0, t0;
        logic co;
        logic [31:0] rv;
        @(negedge clock);
        rv = rnd();
        co = duty | rv[0];
        enable = 1'b0;
        mode = md;
        normal_mode = nrm;
        oversample8 = o8;
        clock_source_select = sel;
        clock_divisor = 16'(n);
        fractional_part = 3'(f);
        clock_output_enable = co;
        ext_run = (sel == 2'h3);
        @(negedge clock);
        enable = 1'b1;
        fe = (md == ubrg_pkg::UBRG_ASYNC && nrm) ? f : 0;
        t = (sel == 2'h1) ? 8 : 1;
        k = (md == ubrg_pkg::UBRG_ISO) ? ratio : 1;
        len = 4 * t * (8 * n + fe) * k;
        es = 32 * k;
        eb = (md == ubrg_pkg::UBRG_ASYNC) ? (o8 ? 4 : 2) : 32;
        if (md == ubrg_pkg::UBRG_SYNC && sel == 2'h3) len = 64 * EXT_HALF;
        else if (n == 0 || sel == 2'h2) begin
            len = 256;
            es = 0;
            eb = 0;
        end
        repeat (len) @(negedge clock);
        ns = 0;
        nb = 0;
        h0 = hi_cnt;
        t0 = tot_cnt;
        meas_on = 1'b1;
        repeat (len) @(negedge clock);
        meas_on = 1'b0;
        // The pin monitor takes its last sample after this edge; wait for it.
        @(negedge clock);
        check({nm, " samples"}, 32'(ns), 32'(es));
        check({nm, " bits"}, 32'(nb), 32'(eb));
        check({nm, " pin enable"}, 32'(sck_oe_r), 32'(co &&
            md != ubrg_pkg::UBRG_ASYNC && sel != 2'h3));
        if (duty) check({nm, " duty"}, 32'(hi_cnt - h0),
            32'((tot_cnt - t0) / 2));
        $display("done %s", nm);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [31:0] r;
        logic [10:0] d1, d2;
        @(negedge clock);
        check("ratio reset", 32'(etu_divide_ratio_r), 32'h00000174);
        check("sample reset", 32'(sample_stb_r), 32'h00000000);
        @(negedge clock);
        arst_n = 1'b1;
        for (int c = 0; c < 16; c++) begin
            clock_division_code = 4'(c);
            rate_adjust_code = 4'(15 - c);
            @(negedge clock);
            check("fi", 32'(fi_factor_r), 32'(fi_exp(c)));
            check("di", 32'(di_factor_r), 32'(di_exp(15 - c)));
        end
        $display("done codes");
        d1 = 11'(rnd());
        d2 = 11'(rnd());
        etu_ratio_wr = 1'b1;
        etu_ratio_wdata = d1;
        @(negedge clock);
        check("ratio first", 32'(etu_divide_ratio_r), 32'(d1));
        etu_ratio_wdata = d2;
        @(negedge clock);
        check("ratio second", 32'(etu_divide_ratio_r), 32'(d2));
        etu_ratio_wdata = 11'h003;
        @(negedge clock);
        etu_ratio_wr = 1'b0;
        $display("done ratio");
        for (int i = 0; i < 5; i++) begin
            r = rnd();
            run_case("async rnd", ubrg_pkg::UBRG_ASYNC, 1'b1, r[3], 2'h0,
                1 + int'(r[7:4] % 4'h6), int'(r[10:8]), 0, 1'b0);
        end
        run_case("async presc", ubrg_pkg::UBRG_ASYNC, 1'b1, 1'b1, 2'h1, 2, 0,
            0, 1'b0);
        run_case("async bypass", ubrg_pkg::UBRG_ASYNC, 1'b1, 1'b0, 2'h0, 1,
            0, 0, 1'b0);
        run_case("async other", ubrg_pkg::UBRG_ASYNC, 1'b0, 1'b0, 2'h0, 3,
            5, 0, 1'b0);
        run_case("sync odd", ubrg_pkg::UBRG_SYNC, 1'b1, 1'b0, 2'h0, 3, 5, 0,
            1'b1);
        run_case("sync even", ubrg_pkg::UBRG_SYNC, 1'b1, 1'b1, 2'h0, 4, 0,
            0, 1'b1);
        run_case("spi", ubrg_pkg::UBRG_SPI, 1'b1, 1'b0, 2'h0, 6, 2, 0,
            1'b0);
        run_case("sync presc", ubrg_pkg::UBRG_SYNC, 1'b1, 1'b0, 2'h1, 2, 0,
            0, 1'b1);
        run_case("sync ext", ubrg_pkg::UBRG_SYNC, 1'b1, 1'b0, 2'h3, 5, 0, 0,
            1'b0);
        run_case("no source", ubrg_pkg::UBRG_ASYNC, 1'b1, 1'b0, 2'h2, 2, 0,
            0, 1'b0);
        run_case("stopped", ubrg_pkg::UBRG_ASYNC, 1'b1, 1'b0, 2'h0, 0, 0, 0,
            1'b0);
        run_case("card", ubrg_pkg::UBRG_ISO, 1'b1, 1'b0, 2'h0, 2, 3, 3,
            1'b1);
        summarize();
    end
endmodule
